// >>> stack_exec_pkg.sv
// Constants for the stack-machine execution unit: opcode fields, codes, condition codes and trap codes.
// Assumes 16-bit words, instruction bit 15 being the most significant bit, and octal opcodes given here in hex.
package stack_exec_pkg;
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 12;
	localparam int IDX_BIT = 11;
	localparam int SUB1_HI = 10;
	localparam int SUB1_LO = 6;
	localparam int CNT_HI = 5;
	localparam int SUB2_HI = 11;
	localparam int SUB2_LO = 8;
	localparam int IMM_HI = 7;
	localparam int MINI_HI = 7;
	localparam int MINI_LO = 4;
	localparam int MOVE_HI = 7;
	localparam int MOVE_LO = 5;
	localparam int PBSEL_BIT = 4;
	localparam int STACK_DELETE_COUNT_HI = 1;
	localparam int MODE_HI = 10;
	localparam int MODE_LO = 9;
	localparam int CCF_HI = 8;
	localparam int CCF_LO = 6;
	localparam int BCC_SIGN = 5;
	localparam int BCC_DISP_HI = 4;
	localparam int BR_IND = 8;
	localparam int BR_SIGN = 7;
	localparam int BR_DISP_HI = 6;
	localparam int REGISTER_PUSH_HI = 7;

	localparam logic [3:0] OPC_SUB1 = 4'h1;
	localparam logic [3:0] OPC_SUB2 = 4'h2;
	localparam logic [3:0] OPC_MEM_BRANCH = 4'hc;
	localparam logic [4:0] SUB1_ASL = 5'h00;
	localparam logic [4:0] SUB1_CSL = 5'h04;
	localparam logic [3:0] SUB2_MOVE_MINI = 4'h0;
	localparam logic [3:0] SUB2_LDI = 4'h2;
	localparam logic [3:0] SUB2_IMMEDIATE_ADD = 4'h5;
	localparam logic [3:0] SUB2_REGISTER_PUSH = 4'h9;
	localparam logic [3:0] MINI_EXTENDED_BANK_LOAD = 4'he;
	localparam logic [3:0] MINI_ABSOLUTE_BANK0_LOAD = 4'hd;
	localparam logic [2:0] MOVE_BYTE_STRING_COMPARE = 3'h5;
	localparam logic [1:0] MODE_BCC = 2'h1;
	localparam logic [1:0] MODE_PREL = 2'h0;
	localparam logic [1:0] MODE_DB = 2'h2;
	localparam logic [2:0] CCF_ALWAYS = 3'h7;

	localparam logic [1:0] CC_GREATER = 2'h0;
	localparam logic [1:0] CC_LESS = 2'h1;
	localparam logic [1:0] CC_EQUAL = 2'h2;

	localparam logic [2:0] TRAP_NONE = 3'h0;
	localparam logic [2:0] TRAP_STACK_UNDERFLOW_TRAP = 3'h1;
	localparam logic [2:0] TRAP_STACK_OVERFLOW_TRAP = 3'h2;
	localparam logic [2:0] TRAP_MODE = 3'h3;
	localparam logic [2:0] TRAP_OVERFLOW_MATH_TRAP = 3'h4;
	localparam logic [2:0] TRAP_UNIMPL = 3'h5;

	localparam logic [15:0] REGISTER_PUSH_RESERVE = 16'h0009;
	localparam logic [7:0] BANK_ZERO = 8'h00;
	localparam int REGISTER_PUSH_ITEMS = 9;
endpackage

// >>> stack_exec_unit.sv
// Execution unit for shifts, branches, byte compare, privileged loads, immediates and register push.
// Assumes the register inputs stay stable while busy_out is high and memory answers req with a one-cycle ack.
module stack_exec_unit
	import stack_exec_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Instruction start
	input  wire logic        start_in,
	input  wire logic [15:0] instr_in,
	input  wire logic        irq_pending_in,
	output logic             busy_out,
	output logic             done_out,
	output logic             trap_out,
	output logic [2:0]       trap_code_out,
	output logic             interrupted_out,
	// Architectural state in
	input  wire logic [15:0] p_in,
	input  wire logic [15:0] sp_in,
	input  wire logic [1:0]  cc_in,
	input  wire logic        carry_in,
	input  wire logic        overflow_in,
	input  wire logic [15:0] db_in,
	input  wire logic [15:0] pb_in,
	input  wire logic [15:0] q_in,
	input  wire logic [15:0] z_in,
	input  wire logic [15:0] dl_in,
	input  wire logic [15:0] x_in,
	input  wire logic [15:0] status_in,
	input  wire logic [7:0]  db_bank_in,
	input  wire logic [7:0]  stack_bank_in,
	input  wire logic [7:0]  pb_bank_in,
	input  wire logic        priv_in,
	// Architectural state out
	output logic [15:0]      p_out,
	output logic [15:0]      sp_out,
	output logic [1:0]       cc_out,
	output logic             carry_out,
	output logic             overflow_out,
	// Memory port
	output logic             mem_req_out,
	output logic             mem_we_out,
	output logic [7:0]       mem_bank_out,
	output logic [15:0]      mem_addr_out,
	output logic [15:0]      mem_wdata_out,
	input  wire logic        mem_ack_in,
	input  wire logic [15:0] mem_rdata_in
);
	typedef enum logic [4:0] {
		ST_IDLE, ST_DECODE, ST_RD_A, ST_RD_B, ST_RD_C, ST_EXEC, ST_IND_RD, ST_LOAD_RD,
		ST_PUSH_WR, ST_CMP, ST_SRC_RD, ST_TGT_RD, ST_WB_A, ST_WB_B, ST_WB_C, ST_DONE
	} state_e;
	typedef enum logic [3:0] {
		K_ASL, K_CSL, K_BCC, K_BR, K_BYTE_STRING_COMPARE, K_EXTENDED_BANK_LOAD, K_ABSOLUTE_BANK0_LOAD, K_IMMEDIATE_ADD, K_LDI, K_REGISTER_PUSH, K_BAD
	} kind_e;

	state_e      state_q;
	kind_e       kind;
	logic [15:0] ir_q, s_q, s_orig_q, p_q, a_q, b_q, c_q, srcw_q, ind_q;
	logic [1:0]  cc_q;
	logic        carry_q, ovf_q, jump_q, intr_q;
	logic [2:0]  trap_q;
	logic [7:0]  ind_bank_q;
	logic [8:0]  pend_q;
	logic        mem_req_q, mem_we_q;
	logic [7:0]  mem_bank_q;
	logic [15:0] mem_addr_q, mem_wdata_q;
	logic        xfer;

	function automatic logic [1:0] cc_of(input logic [15:0] w);
		if (w == 16'h0000)
			return CC_EQUAL;
		else if (w[15])
			return CC_LESS;
		else
			return CC_GREATER;
	endfunction

	assign xfer = mem_req_q && mem_ack_in;

	// Decode of the held instruction
	always_comb begin
		kind = K_BAD;
		case (ir_q[OPC_HI:OPC_LO])
			OPC_SUB1: begin
				if (ir_q[SUB1_HI:SUB1_LO] == SUB1_ASL)
					kind = K_ASL;
				else if (ir_q[SUB1_HI:SUB1_LO] == SUB1_CSL)
					kind = K_CSL;
			end
			OPC_MEM_BRANCH: kind = (ir_q[MODE_HI:MODE_LO] == MODE_BCC) ? K_BCC : K_BR;
			OPC_SUB2: begin
				case (ir_q[SUB2_HI:SUB2_LO])
					SUB2_LDI: kind = K_LDI;
					SUB2_IMMEDIATE_ADD: kind = K_IMMEDIATE_ADD;
					SUB2_REGISTER_PUSH: kind = K_REGISTER_PUSH;
					SUB2_MOVE_MINI: begin
						if (ir_q[MOVE_HI:MOVE_LO] == MOVE_BYTE_STRING_COMPARE)
							kind = K_BYTE_STRING_COMPARE;
						else if (ir_q[MINI_HI:MINI_LO] == MINI_EXTENDED_BANK_LOAD && ir_q[STACK_DELETE_COUNT_HI:0] == 2'h0)
							kind = K_EXTENDED_BANK_LOAD;
						else if (ir_q[MINI_HI:MINI_LO] == MINI_ABSOLUTE_BANK0_LOAD && !ir_q[0])
							kind = K_ABSOLUTE_BANK0_LOAD;
					end
					default: kind = K_BAD;
				endcase
			end
			default: kind = K_BAD;
		endcase
	end

	// Operand arithmetic
	logic [5:0]  shamt;
	logic [14:0] asl_mag;
	logic [31:0] rot_dbl;
	logic [16:0] add_sum;
	logic [15:0] depth, need_depth, push_words;
	logic [15:0] bcc_off, br_off, disp_base, bcc_tgt, br_prel;
	logic        bcc_take;
	logic [15:0] src_addr, tgt_addr;
	logic [7:0]  src_byte, tgt_byte;
	logic [15:0] a_step, bc_step;
	logic [3:0]  pick;
	logic [15:0] push_val;
	logic [2:0]  ccf;

	always_comb begin
		shamt = ir_q[CNT_HI:0] + (ir_q[IDX_BIT] ? x_in[5:0] : 6'h00);
		asl_mag = a_q[14:0] << shamt;
		rot_dbl = {a_q, a_q} << shamt[3:0];
		add_sum = {1'b0, a_q} + {9'h000, ir_q[IMM_HI:0]};
		depth = s_q - db_in;
		need_depth = 16'h0000;
		push_words = 16'h0000;
		case (kind)
			K_ASL, K_CSL, K_IMMEDIATE_ADD: need_depth = 16'h0001;
			K_EXTENDED_BANK_LOAD: need_depth = 16'h0002;
			K_BYTE_STRING_COMPARE: need_depth = 16'h0003;
			default: need_depth = 16'h0000;
		endcase
		case (kind)
			K_LDI, K_EXTENDED_BANK_LOAD, K_ABSOLUTE_BANK0_LOAD: push_words = 16'h0001;
			K_REGISTER_PUSH: push_words = REGISTER_PUSH_RESERVE;
			default: push_words = 16'h0000;
		endcase
		ccf = ir_q[CCF_HI:CCF_LO];
		bcc_take = (ccf == CCF_ALWAYS) || (ccf[0] && cc_q == CC_LESS) ||
			(ccf[1] && cc_q == CC_EQUAL) || (ccf[2] && cc_q == CC_GREATER);
		bcc_off = {11'h000, ir_q[BCC_DISP_HI:0]};
		bcc_tgt = ir_q[BCC_SIGN] ? p_q - bcc_off : p_q + bcc_off;
		br_off = {9'h000, ir_q[BR_DISP_HI:0]};
		br_prel = ir_q[BR_SIGN] ? p_q - br_off : p_q + br_off;
		if (ir_q[MODE_HI:MODE_LO] == MODE_DB)
			disp_base = db_in + br_off;
		else if (ir_q[BR_IND])
			disp_base = s_q - br_off;
		else
			disp_base = ir_q[BR_SIGN] ? q_in - br_off : q_in + br_off;
		src_addr = (ir_q[PBSEL_BIT] ? pb_in : db_in) + {b_q[15], b_q[15:1]};
		tgt_addr = db_in + {c_q[15], c_q[15:1]};
		src_byte = b_q[0] ? srcw_q[7:0] : srcw_q[15:8];
		tgt_byte = c_q[0] ? mem_rdata_in[7:0] : mem_rdata_in[15:8];
		a_step = a_q[15] ? a_q + 16'h0001 : a_q - 16'h0001;
		bc_step = a_q[15] ? 16'hffff : 16'h0001;
		pick = 4'h0;
		for (int i = REGISTER_PUSH_ITEMS - 1; i >= 0; i--) begin
			if (pend_q[i])
				pick = i[3:0];
		end
		case (pick)
			4'h0: push_val = s_orig_q - db_in;
			4'h1: push_val = q_in - db_in;
			4'h2: push_val = x_in;
			4'h3: push_val = status_in;
			4'h4: push_val = z_in - db_in;
			4'h5: push_val = dl_in - db_in;
			4'h6: push_val = {8'h00, db_bank_in};
			4'h7: push_val = db_in;
			default: push_val = {8'h00, stack_bank_in};
		endcase
		if (kind != K_REGISTER_PUSH)
			push_val = (kind == K_LDI) ? {8'h00, ir_q[IMM_HI:0]} : a_q;
	end

	// Access wanted by the current state
	logic        acc_need, acc_we;
	logic [7:0]  acc_bank;
	logic [15:0] acc_addr, acc_wdata;

	always_comb begin
		acc_need = 1'b1;
		acc_we = 1'b0;
		acc_bank = stack_bank_in;
		acc_addr = s_q;
		acc_wdata = 16'h0000;
		case (state_q)
			ST_RD_A: acc_addr = s_q;
			ST_RD_B: acc_addr = s_q - 16'h0001;
			ST_RD_C: acc_addr = s_q - 16'h0002;
			ST_IND_RD: begin
				acc_bank = ind_bank_q;
				acc_addr = ind_q;
			end
			ST_LOAD_RD: begin
				acc_bank = (kind == K_EXTENDED_BANK_LOAD) ? b_q[7:0] : BANK_ZERO;
				acc_addr = (kind == K_EXTENDED_BANK_LOAD) ? a_q : x_in;
			end
			ST_PUSH_WR: begin
				acc_we = 1'b1;
				acc_addr = s_q + 16'h0001;
				acc_wdata = push_val;
			end
			ST_SRC_RD: begin
				acc_bank = ir_q[PBSEL_BIT] ? pb_bank_in : db_bank_in;
				acc_addr = src_addr;
			end
			ST_TGT_RD: begin
				acc_bank = db_bank_in;
				acc_addr = tgt_addr;
			end
			ST_WB_A: begin
				acc_we = 1'b1;
				acc_wdata = a_q;
			end
			ST_WB_B: begin
				acc_we = 1'b1;
				acc_addr = s_q - 16'h0001;
				acc_wdata = b_q;
			end
			ST_WB_C: begin
				acc_we = 1'b1;
				acc_addr = s_q - 16'h0002;
				acc_wdata = c_q;
			end
			default: acc_need = 1'b0;
		endcase
	end

	// Memory port: request held until ack, never reissued in the ack cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_bank_q <= 8'h00;
			mem_addr_q <= 16'h0000;
			mem_wdata_q <= 16'h0000;
		end else if (xfer) begin
			mem_req_q <= 1'b0;
		end else if (!mem_req_q && acc_need) begin
			mem_req_q <= 1'b1;
			mem_we_q <= acc_we;
			mem_bank_q <= acc_bank;
			mem_addr_q <= acc_addr;
			mem_wdata_q <= acc_wdata;
		end
	end

	// Sequencer and datapath
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			ir_q <= 16'h0000;
			s_q <= 16'h0000;
			s_orig_q <= 16'h0000;
			p_q <= 16'h0000;
			a_q <= 16'h0000;
			b_q <= 16'h0000;
			c_q <= 16'h0000;
			srcw_q <= 16'h0000;
			ind_q <= 16'h0000;
			ind_bank_q <= 8'h00;
			cc_q <= CC_EQUAL;
			carry_q <= 1'b0;
			ovf_q <= 1'b0;
			jump_q <= 1'b0;
			intr_q <= 1'b0;
			trap_q <= TRAP_NONE;
			pend_q <= 9'h000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_in) begin
						ir_q <= instr_in;
						s_q <= sp_in;
						s_orig_q <= sp_in;
						p_q <= p_in;
						cc_q <= cc_in;
						carry_q <= carry_in;
						ovf_q <= overflow_in;
						jump_q <= 1'b0;
						intr_q <= 1'b0;
						trap_q <= TRAP_NONE;
						state_q <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					pend_q <= {ir_q[REGISTER_PUSH_HI], ir_q[REGISTER_PUSH_HI - 1], ir_q[REGISTER_PUSH_HI - 1], ir_q[REGISTER_PUSH_HI - 2],
						ir_q[REGISTER_PUSH_HI - 3], ir_q[REGISTER_PUSH_HI - 4], ir_q[REGISTER_PUSH_HI - 5], ir_q[REGISTER_PUSH_HI - 6],
						ir_q[REGISTER_PUSH_HI - 7]};
					state_q <= ST_DONE;
					if (kind == K_BAD) begin
						trap_q <= TRAP_UNIMPL;
					end else if (!priv_in && (kind == K_EXTENDED_BANK_LOAD || kind == K_ABSOLUTE_BANK0_LOAD ||
						(kind == K_REGISTER_PUSH && ir_q[REGISTER_PUSH_HI -: 2] != 2'h0))) begin
						trap_q <= TRAP_MODE;
					end else if (depth < need_depth) begin
						trap_q <= TRAP_STACK_UNDERFLOW_TRAP;
					end else if ({1'b0, s_q} + {1'b0, push_words} > {1'b0, z_in}) begin
						trap_q <= TRAP_STACK_OVERFLOW_TRAP;
					end else begin
						case (kind)
							K_ASL, K_CSL, K_IMMEDIATE_ADD, K_EXTENDED_BANK_LOAD, K_BYTE_STRING_COMPARE: state_q <= ST_RD_A;
							K_LDI, K_REGISTER_PUSH: state_q <= (kind == K_REGISTER_PUSH && ir_q[REGISTER_PUSH_HI:0] == 8'h00) ? ST_DONE : ST_PUSH_WR;
							K_ABSOLUTE_BANK0_LOAD: state_q <= ST_LOAD_RD;
							K_BCC: begin
								if (bcc_take && ir_q[IDX_BIT]) begin
									ind_q <= bcc_tgt;
									ind_bank_q <= pb_bank_in;
									state_q <= ST_IND_RD;
								end else if (bcc_take) begin
									p_q <= bcc_tgt;
									jump_q <= 1'b1;
								end
							end
							K_BR: begin
								if (ir_q[MODE_HI:MODE_LO] == MODE_PREL && !ir_q[BR_IND]) begin
									p_q <= br_prel + (ir_q[IDX_BIT] ? x_in : 16'h0000);
									jump_q <= 1'b1;
								end else begin
									ind_q <= (ir_q[MODE_HI:MODE_LO] == MODE_PREL) ? br_prel : disp_base;
									ind_bank_q <= (ir_q[MODE_HI:MODE_LO] == MODE_PREL) ? pb_bank_in :
										(ir_q[MODE_HI:MODE_LO] == MODE_DB) ? db_bank_in : stack_bank_in;
									state_q <= ST_IND_RD;
								end
							end
							default: state_q <= ST_DONE;
						endcase
					end
				end
				ST_RD_A: if (xfer) begin
					a_q <= mem_rdata_in;
					state_q <= (kind == K_EXTENDED_BANK_LOAD || kind == K_BYTE_STRING_COMPARE) ? ST_RD_B : ST_EXEC;
				end
				ST_RD_B: if (xfer) begin
					b_q <= mem_rdata_in;
					state_q <= (kind == K_EXTENDED_BANK_LOAD) ? ST_LOAD_RD : ST_RD_C;
				end
				ST_RD_C: if (xfer) begin
					c_q <= mem_rdata_in;
					state_q <= ST_CMP;
				end
				ST_EXEC: begin
					state_q <= ST_WB_A;
					if (kind == K_IMMEDIATE_ADD) begin
						a_q <= add_sum[15:0];
						cc_q <= cc_of(add_sum[15:0]);
						carry_q <= add_sum[16];
						ovf_q <= !a_q[15] && add_sum[15];
						if (!a_q[15] && add_sum[15])
							trap_q <= TRAP_OVERFLOW_MATH_TRAP;
					end else if (kind == K_ASL) begin
						a_q <= {a_q[15], asl_mag};
						cc_q <= cc_of({a_q[15], asl_mag});
					end else begin
						a_q <= rot_dbl[31:16];
						cc_q <= cc_of(rot_dbl[31:16]);
					end
				end
				ST_IND_RD: if (xfer) begin
					if (kind == K_BCC)
						p_q <= ind_q + mem_rdata_in;
					else if (ir_q[MODE_HI:MODE_LO] == MODE_PREL)
						p_q <= ind_q + mem_rdata_in + (ir_q[IDX_BIT] ? x_in : 16'h0000);
					else
						p_q <= pb_in + mem_rdata_in + (ir_q[IDX_BIT] ? x_in : 16'h0000);
					jump_q <= 1'b1;
					state_q <= ST_DONE;
				end
				ST_LOAD_RD: if (xfer) begin
					a_q <= mem_rdata_in;
					cc_q <= cc_of(mem_rdata_in);
					state_q <= ST_PUSH_WR;
				end
				ST_PUSH_WR: if (xfer) begin
					s_q <= s_q + 16'h0001;
					if (kind == K_LDI)
						cc_q <= cc_of(push_val);
					pend_q[pick] <= 1'b0;
					if (kind != K_REGISTER_PUSH || (pend_q & ~(9'h001 << pick)) == 9'h000)
						state_q <= ST_DONE;
				end
				ST_CMP: begin
					if (a_q == 16'h0000) begin
						cc_q <= CC_EQUAL;
						state_q <= ST_WB_A;
					end else begin
						state_q <= ST_SRC_RD;
					end
				end
				ST_SRC_RD: if (xfer) begin
					srcw_q <= mem_rdata_in;
					state_q <= ST_TGT_RD;
				end
				ST_TGT_RD: if (xfer) begin
					if (src_byte != tgt_byte) begin
						cc_q <= (src_byte < tgt_byte) ? CC_LESS : CC_GREATER;
						state_q <= ST_WB_A;
					end else begin
						a_q <= a_step;
						b_q <= b_q + bc_step;
						c_q <= c_q + bc_step;
						// Stack words are rewritten before yielding, so a restart picks up the same state
						if (irq_pending_in && a_step != 16'h0000) begin
							intr_q <= 1'b1;
							state_q <= ST_WB_A;
						end else begin
							state_q <= ST_CMP;
						end
					end
				end
				ST_WB_A: if (xfer) begin
					state_q <= (kind == K_BYTE_STRING_COMPARE) ? ST_WB_B : ST_DONE;
				end
				ST_WB_B: if (xfer) begin
					state_q <= ST_WB_C;
				end
				ST_WB_C: if (xfer) begin
					if (!intr_q)
						s_q <= s_q - {14'h0000, ir_q[STACK_DELETE_COUNT_HI:0]};
					state_q <= ST_DONE;
				end
				ST_DONE: begin
					if (trap_q == TRAP_NONE && !intr_q && !jump_q)
						p_q <= p_q + 16'h0001;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign busy_out = (state_q != ST_IDLE);
	assign done_out = (state_q == ST_DONE);
	assign trap_out = (state_q == ST_DONE) && (trap_q != TRAP_NONE);
	assign trap_code_out = trap_q;
	assign interrupted_out = (state_q == ST_DONE) && intr_q;
	assign p_out = p_q;
	assign sp_out = s_q;
	assign cc_out = cc_q;
	assign carry_out = carry_q;
	assign overflow_out = ovf_q;
	assign mem_req_out = mem_req_q;
	assign mem_we_out = mem_we_q;
	assign mem_bank_out = mem_bank_q;
	assign mem_addr_out = mem_addr_q;
	assign mem_wdata_out = mem_wdata_q;
endmodule

// >>> main_memory_model.sv
// Behavioural main memory answering the execution unit's word requests.
// Assumes one request at a time; the ack follows after delay_in waiting cycles.
module main_memory_model (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Request
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic [7:0]  bank_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [1:0]  delay_in,
	// Answer
	output logic             ack_out,
	output logic [15:0]      rdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] words [logic [23:0]];
	logic [1:0]  wait_q;
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_out <= 1'b0;
			wait_q <= 2'h0;
			rdata_out <= 16'h0;
		end else begin
			ack_out <= 1'b0;
			// Outside the ack cycle the data lines invert every cycle, so the last word comes back on every second cycle
			rdata_out <= ~rdata_out;
			if (req_in && !ack_out) begin
				if (wait_q == delay_in) begin
					ack_out <= 1'b1;
					wait_q <= 2'h0;
					if (we_in)
						words[{bank_in, addr_in}] = wdata_in;
					else if (words.exists({bank_in, addr_in}))
						rdata_out <= words[{bank_in, addr_in}];
					else
						rdata_out <= ~addr_in;
				end else begin
					wait_q <= wait_q + 2'h1;
				end
			end
		end
	end
endmodule

// >>> stack_exec_assertions.sv
// Port checker for the execution unit.
// Assumes one clock domain and the start/done and req/ack handshakes of the unit.
module stack_exec_assertions
	import stack_exec_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        start_in,
	input wire logic [15:0] instr_in,
	input wire logic        busy_out,
	input wire logic        done_out,
	input wire logic        trap_out,
	input wire logic [2:0]  trap_code_out,
	input wire logic        interrupted_out,
	input wire logic [15:0] sp_in,
	input wire logic [15:0] db_in,
	input wire logic [15:0] z_in,
	input wire logic [1:0]  cc_in,
	input wire logic        priv_in,
	input wire logic [1:0]  cc_out,
	input wire logic        mem_req_out,
	input wire logic        mem_we_out,
	input wire logic [15:0] mem_addr_out,
	input wire logic [15:0] mem_wdata_out,
	input wire logic        mem_ack_in
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic        taken;
	logic [15:0] instr_q;
	logic [15:0] sp_q;
	logic [1:0]  cc_q;
	assign taken = start_in && !busy_out;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			instr_q <= 16'h0;
			sp_q <= 16'h0;
			cc_q <= 2'h0;
		end else if (taken) begin
			instr_q <= instr_in;
			sp_q <= sp_in;
			cc_q <= cc_in;
		end
	end
	sequence s_ldi_start;
		taken && instr_in[15:8] == 8'h22 && sp_in < z_in;
	endsequence
	sequence s_ldi_write;
		mem_req_out && mem_we_out && mem_addr_out == sp_q + 16'h1 && mem_wdata_out == {8'h00, instr_q[7:0]};
	endsequence
	property p_ldi_push;
		s_ldi_start |-> ##[1:8] s_ldi_write;
	endproperty
	property p_done_pulse;
		done_out |=> !done_out && !busy_out;
	endproperty
	property p_trap_flag;
		trap_out && trap_code_out == TRAP_OVERFLOW_MATH_TRAP |-> instr_q[15:8] == 8'h25;
	endproperty
	property p_intr_done;
		interrupted_out |-> done_out && !trap_out;
	endproperty
	property p_req_hold;
		mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_wdata_out) && $stable(mem_we_out);
	endproperty
	property p_req_drop;
		mem_ack_in |=> !mem_req_out;
	endproperty
	property p_br_cc;
		done_out && instr_q[15:12] == OPC_MEM_BRANCH |=> cc_out == cc_q;
	endproperty
	property p_shift_stack_underflow_trap;
		taken && instr_in[15:12] == OPC_SUB1 && (instr_in[10:6] == SUB1_ASL || instr_in[10:6] == SUB1_CSL) && sp_in == db_in
			|-> ##[1:3] done_out && trap_code_out == TRAP_STACK_UNDERFLOW_TRAP;
	endproperty
	property p_push_mode;
		taken && instr_in[15:8] == 8'h29 && !priv_in && instr_in[7:6] != 2'b00 |-> ##[1:3] trap_out && trap_code_out == TRAP_MODE;
	endproperty
	property p_push_ovf;
		taken && instr_in[15:8] == 8'h29 && priv_in && ({1'b0, sp_in} + 17'h9 > {1'b0, z_in})
			|-> ##[1:3] trap_out && trap_code_out == TRAP_STACK_OVERFLOW_TRAP;
	endproperty
	a_ldi_push: assert property (p_ldi_push) else $error("immediate push write wrong");
	a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
	a_trap_flag: assert property (p_trap_flag) else $error("arithmetic trap outside immediate add");
	a_intr_done: assert property (p_intr_done) else $error("interrupt outside done");
	a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
	a_req_drop: assert property (p_req_drop) else $error("request held after ack");
	a_br_cc: assert property (p_br_cc) else $error("branch changed condition code");
	a_shift_stack_underflow_trap: assert property (p_shift_stack_underflow_trap) else $error("shift underflow not trapped");
	a_push_mode: assert property (p_push_mode) else $error("privileged push not trapped");
	a_push_ovf: assert property (p_push_ovf) else $error("push overflow not trapped");
endmodule
bind stack_exec_unit stack_exec_assertions u_stack_exec_assertions (.*);

// >>> stack_cpu_shift_branch_move_tb.sv
// Self-checking bench for the execution unit against a behavioural memory.
// Assumes the unit's start/done handshake; inputs change 1 ns after each rising edge.
module stack_cpu_shift_branch_move_tb import stack_exec_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] S0 = 16'h0200;
	localparam logic [15:0] P0 = 16'h1000;
	logic        clk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, irq_pending_in = 1'b0, priv_in = 1'b1;
	logic        carry_in = 1'b0, overflow_in = 1'b0, intr_seen;
	logic [1:0]  cc_in = 2'h2, delay_in = 2'h0, cc_out;
	logic [15:0] instr_in = 16'h0, p_in = P0, sp_in = S0, db_in = 16'h0100, pb_in = 16'h2000, q_in = 16'h0180;
	logic [15:0] z_in = 16'h0300, dl_in = 16'h0400, x_in = 16'h0, status_in = 16'h0;
	logic [7:0]  db_bank_in = 8'h01, stack_bank_in = 8'h01, pb_bank_in = 8'h01, mem_bank_out;
	logic        busy_out, done_out, trap_out, interrupted_out, carry_out, overflow_out, mem_req_out, mem_we_out, mem_ack_in;
	logic [2:0]  trap_code_out, trap_seen;
	logic [15:0] p_out, sp_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
	logic [15:0] pushed [9];
	logic [15:0] sh_op [5] = '{16'h1001, 16'h1101, 16'h1903, 16'h183f, 16'h1004};
	logic [15:0] sh_x [5] = '{16'h7, 16'h0, 16'h5, 16'h1, 16'h0};
	logic [15:0] sh_a [5] = '{16'h8001, 16'h8001, 16'h1234, 16'h1234, 16'h0};
	logic [15:0] sh_r [5] = '{16'h8002, 16'h0003, 16'h3412, 16'h1234, 16'h0};
	logic [1:0]  sh_cc [5] = '{CC_LESS, CC_GREATER, CC_GREATER, CC_GREATER, CC_EQUAL};
	int          error_cnt = 0, n_compared = 0, i, m, c;
	always #2.5 clk_in = ~clk_in;
	stack_exec_unit u_stack_exec_unit (.*);
	main_memory_model u_main_memory_model (.clk_in(clk_in), .rst_in(rst_in), .req_in(mem_req_out), .we_in(mem_we_out),
		.bank_in(mem_bank_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .delay_in(delay_in),
		.ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic put(input logic [7:0] bank, input logic [15:0] addr, input logic [15:0] val);
		u_main_memory_model.words[{bank, addr}] = val;
	endtask
	function automatic logic [15:0] stk(input logic [15:0] addr);
		return u_main_memory_model.words[{stack_bank_in, addr}];
	endfunction
	task automatic abc(input logic [15:0] a, input logic [15:0] b, input logic [15:0] t);
		put(stack_bank_in, S0, a);
		put(stack_bank_in, S0 - 16'h1, b);
		put(stack_bank_in, S0 - 16'h2, t);
	endtask
	task automatic chk3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] t);
		check(stk(S0), a);
		check(stk(S0 - 16'h1), b);
		check(stk(S0 - 16'h2), t);
	endtask
	// One instruction; state outputs are read the cycle after done
	task automatic run(input logic [15:0] op);
		int k;
		instr_in = op;
		start_in = 1'b1;
		@(posedge clk_in);
		#1 start_in = 1'b0;
		for (k = 0; k < 300 && done_out !== 1'b1; k++) begin
			@(posedge clk_in);
			#1;
		end
		if (k == 300) begin
			error_cnt++;
			test_done();
		end
		trap_seen = trap_code_out;
		intr_seen = interrupted_out;
		@(posedge clk_in);
		#1;
	endtask
	initial begin
		repeat (8) @(posedge clk_in);
		#1 rst_in = 1'b0;
		for (i = 0; i < 5; i++) begin
			x_in = sh_x[i];
			put(stack_bank_in, S0, sh_a[i]);
			run(sh_op[i]);
			check(stk(S0), sh_r[i]);
			check(16'(cc_out), 16'(sh_cc[i]));
			check(p_out, P0 + 16'h1);
		end
		sp_in = db_in;
		run(16'h1001);
		check(16'(trap_seen), 16'(TRAP_STACK_UNDERFLOW_TRAP));
		check(sp_out, db_in);
		sp_in = S0;
		$display("test shifts done");
		for (m = 0; m < 8; m++)
			for (c = 0; c < 3; c++) begin
				cc_in = c[1:0];
				run({4'hc, 3'b001, m[2:0], m[0], 5'h1f});
				check(p_out, m[c == 0 ? 2 : c == 1 ? 0 : 1] ? (m[0] ? P0 - 16'h1f : P0 + 16'h1f) : P0 + 16'h1);
				check(16'(cc_out), 16'(c));
			end
		cc_in = CC_LESS;
		x_in = 16'h3;
		run(16'hc807);
		check(p_out, P0 + 16'ha);
		check(16'(cc_out), 16'(CC_LESS));
		run(16'hc085);
		check(p_out, P0 - 16'h5);
		put(db_bank_in, db_in + 16'h3, 16'h0040);
		run(16'hcc03);
		check(p_out, pb_in + 16'h0043);
		put(pb_bank_in, P0 + 16'h4, 16'h0020);
		run(16'hcbc4);
		check(p_out, P0 + 16'h0024);
		put(stack_bank_in, S0 - 16'h2, 16'h0010);
		run(16'hc702);
		check(p_out, pb_in + 16'h0010);
		$display("test branches done");
		run(16'h22ff);
		check(stk(S0 + 16'h1), 16'h00ff);
		check(sp_out, S0 + 16'h1);
		check(16'(cc_out), 16'(CC_GREATER));
		sp_in = z_in;
		run(16'h2205);
		check(16'(trap_seen), 16'(TRAP_STACK_OVERFLOW_TRAP));
		sp_in = S0;
		put(stack_bank_in, S0, 16'hfffe);
		run(16'h2505);
		check(stk(S0), 16'h0003);
		check({14'h0, carry_out, overflow_out}, 16'h2);
		put(stack_bank_in, S0, 16'h7fff);
		run(16'h2501);
		check(16'(trap_seen), 16'(TRAP_OVERFLOW_MATH_TRAP));
		check(16'(overflow_out), 16'h1);
		$display("test immediates done");
		// Slow memory from here on
		delay_in = 2'h2;
		db_bank_in = 8'h05;
		x_in = 16'h1111;
		status_in = 16'h2222;
		run(16'h29ff);
		pushed = '{S0 - db_in, q_in - db_in, x_in, status_in, z_in - db_in, dl_in - db_in, {8'h0, db_bank_in}, db_in,
			{8'h0, stack_bank_in}};
		for (i = 0; i < 9; i++)
			check(stk(S0 + 16'(i + 1)), pushed[i]);
		check(sp_out, S0 + 16'h9);
		db_bank_in = 8'h01;
		priv_in = 1'b0;
		run(16'h2980);
		check(16'(trap_seen), 16'(TRAP_MODE));
		run(16'h20d0);
		check(16'(trap_seen), 16'(TRAP_MODE));
		priv_in = 1'b1;
		sp_in = z_in - 16'h8;
		run(16'h2901);
		check(16'(trap_seen), 16'(TRAP_STACK_OVERFLOW_TRAP));
		sp_in = S0;
		x_in = 16'h0050;
		put(8'h00, 16'h0050, 16'h8123);
		run(16'h20d0);
		check(stk(S0 + 16'h1), 16'h8123);
		check(16'(cc_out), 16'(CC_LESS));
		abc(16'h0060, 16'h0002, 16'h0);
		put(8'h02, 16'h0060, 16'h0000);
		run(16'h20e0);
		check(stk(S0 + 16'h1), 16'h0);
		check(16'(cc_out), 16'(CC_EQUAL));
		$display("test pushes and loads done");
		put(db_bank_in, db_in, 16'h4142);
		put(db_bank_in, db_in + 16'h2, 16'h4142);
		abc(16'h2, 16'h0, 16'h4);
		irq_pending_in = 1'b1;
		run(16'h20a3);
		check(16'(intr_seen), 16'h1);
		chk3(16'h1, 16'h1, 16'h5);
		check(sp_out, S0);
		irq_pending_in = 1'b0;
		run(16'h20a3);
		check(16'(cc_out), 16'(CC_EQUAL));
		chk3(16'h0, 16'h2, 16'h6);
		check(sp_out, S0 - 16'h3);
		put(db_bank_in, db_in + 16'h2, 16'h4143);
		abc(16'h2, 16'h0, 16'h4);
		run(16'h20a0);
		check(16'(cc_out), 16'(CC_LESS));
		chk3(16'h1, 16'h1, 16'h5);
		put(pb_bank_in, pb_in, 16'h0055);
		put(db_bank_in, db_in + 16'h1, 16'h0055);
		abc(16'hffff, 16'h1, 16'h3);
		run(16'h20b0);
		check(16'(cc_out), 16'(CC_EQUAL));
		chk3(16'h0, 16'h0, 16'h2);
		$display("test byte compare done");
		test_done();
	end
endmodule
